/* File: include/lpm_pkg.sv */
// Constants, field layout and state type of the low power mode and priority block
package lpm_pkg;

	// ------------------------------------------------------------
	// Source count and priority fields
	// ------------------------------------------------------------
	localparam int NUM_SRC = 6;
	localparam int SRC_W = 3;
	localparam int LVL_W = 2;
	localparam int NUM_LVL = 4;
	localparam int EXT_NUM = 2;
	localparam logic [SRC_W-1:0] SRC_EXT0 = 3'h0;
	localparam logic [SRC_W-1:0] SRC_EXT1 = 3'h2;
	localparam logic [7:0] PRIO_RESET = 8'h00;
	localparam logic [7:0] PRIO_FIELD_MASK = 8'h3F;

	// ------------------------------------------------------------
	// Register indices and byte addresses
	// ------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [7:0] PRIO_HIGH_INDEX = 8'hB7;
	localparam logic [7:0] PRIO_LOW_INDEX = 8'hB8;
	localparam logic [ADDR_W-1:0] PRIO_HIGH_ADDR = {2'h0, PRIO_HIGH_INDEX, 2'h0};
	localparam logic [ADDR_W-1:0] PRIO_LOW_ADDR = {2'h0, PRIO_LOW_INDEX, 2'h0};
	localparam logic [ADDR_W-1:0] PWR_CTRL_ADDR = 12'h000;
	localparam logic [ADDR_W-1:0] INT_CTRL_ADDR = 12'h004;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h008;

	// ------------------------------------------------------------
	// Power control fields
	// ------------------------------------------------------------
	localparam int PWR_IDLE_BIT = 0;
	localparam int PWR_PDOWN_BIT = 1;
	localparam logic [1:0] PWR_RESET = 2'h0;

	// ------------------------------------------------------------
	// Interrupt control fields
	// ------------------------------------------------------------
	localparam int INT_CTRL_W = 10;
	localparam int INT_EN_LSB = 0;
	localparam int INT_GLOBAL_BIT = 7;
	localparam int INT_EDGE_LSB = 8;
	localparam logic [INT_CTRL_W-1:0] INT_CTRL_RESET = 10'h000;

	// ------------------------------------------------------------
	// Status fields
	// ------------------------------------------------------------
	localparam int STAT_IDLE_BIT = 0;
	localparam int STAT_PDOWN_BIT = 1;
	localparam int STAT_HOLD_BIT = 2;
	localparam int STAT_INSERV_LSB = 4;

	// ------------------------------------------------------------
	// Wake timing and synchroniser
	// ------------------------------------------------------------
	localparam int WAKE_CNT_W = 11;
	localparam logic [WAKE_CNT_W-1:0] WAKE_HOLD_CYCLES = 11'h400;
	localparam logic [WAKE_CNT_W-1:0] WAKE_CNT_ONE = 11'h001;
	localparam logic [EXT_NUM-1:0] PIN_IDLE_LEVEL = 2'h3;

	// Mode states
	typedef enum logic [2:0] {ST_RUN, ST_IDLE, ST_PDOWN, ST_WAKE_HOLD} mode_state_t;

endpackage

/* File: rtl/low_power_mode_and_priority.sv */
// Idle and power-down control with four level interrupt priority selection
`timescale 1ns/1ns
module low_power_mode_and_priority (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Interrupt requests and CPU handshake
	input wire logic [lpm_pkg::NUM_SRC-1:0] intReq,
	input wire logic intAck,
	input wire logic retiDone,
	output logic intValid,
	output logic [lpm_pkg::SRC_W-1:0] intSource,
	output logic [lpm_pkg::LVL_W-1:0] intLevel,
	// External interrupt pins, active low
	input wire logic [lpm_pkg::EXT_NUM-1:0] extIntPinN,
	// Core control
	output logic cpuHalt,
	output logic sysClkEnable,
	// Bus strobes
	input wire logic coreAle,
	input wire logic coreProgramStoreStrobe,
	output logic addrLatchStrobe,
	output logic programStoreStrobe
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	lpm_pkg::mode_state_t state_q; // Mode state
	lpm_pkg::mode_state_t state_d; // Next mode state
	logic [1:0] powerCtrl_q; // Idle and power-down request bits
	logic [1:0] powerCtrl_d; // Next request bits
	logic [lpm_pkg::INT_CTRL_W-1:0] intCtrl_q; // Enables, global enable, edge modes
	logic [7:0] prioHigh_q; // Priority high register
	logic [7:0] prioLow_q; // Priority low register
	logic [lpm_pkg::NUM_LVL-1:0] inServ_q; // Levels in service
	logic [lpm_pkg::NUM_LVL-1:0] inServ_d; // Next in-service set
	logic [lpm_pkg::WAKE_CNT_W-1:0] wakeCnt_q; // Cycles of pin held low
	logic [lpm_pkg::WAKE_CNT_W-1:0] wakeCnt_d; // Next count
	logic wrPend_q; // Write data phase pending
	logic [lpm_pkg::ADDR_W-1:0] wrAddr_q; // Write address
	logic [31:0] hrdata_q; // Read data
	logic intValid_q; // Registered request valid
	logic [lpm_pkg::SRC_W-1:0] intSource_q; // Registered source
	logic [lpm_pkg::LVL_W-1:0] intLevel_q; // Registered level
	logic ale_q; // Address latch strobe
	logic pss_q; // Program store strobe
	logic [lpm_pkg::EXT_NUM-1:0] pinLevel; // Filtered pin levels

	// ------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------
	pin_sync uPinSync (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.pinRaw(extIntPinN),
		.pinLevel(pinLevel)
	);

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire addrReq = hsel && htrans[1]; // Transfer offered on the bus
	wire addrPhase = addrReq && hready; // Transfer taken
	wire [lpm_pkg::ADDR_W-1:0] busAddr = haddr[lpm_pkg::ADDR_W-1:0]; // Offset bits
	// Stall kept free of hready, which is our own hreadyout on a one-slave bus
	wire readStall = wrPend_q && addrReq && !hwrite; // Read waits for write to land
	wire readTake = addrPhase && !hwrite && !wrPend_q; // Read sampled now
	wire writeTake = addrPhase && hwrite; // Write address taken
	wire pwrWrite = wrPend_q && (wrAddr_q == lpm_pkg::PWR_CTRL_ADDR); // Power control write
	wire intCtrlWrite = wrPend_q && (wrAddr_q == lpm_pkg::INT_CTRL_ADDR); // Control write
	wire prioHighWrite = wrPend_q && (wrAddr_q == lpm_pkg::PRIO_HIGH_ADDR); // High write
	wire prioLowWrite = wrPend_q && (wrAddr_q == lpm_pkg::PRIO_LOW_ADDR); // Low write
	wire idleReq = pwrWrite && hwdata[lpm_pkg::PWR_IDLE_BIT]; // Idle request written
	wire pdownReq = pwrWrite && hwdata[lpm_pkg::PWR_PDOWN_BIT]; // Power-down written

	// ------------------------------------------------------------
	// Interrupt qualification
	// ------------------------------------------------------------
	wire globalEn = intCtrl_q[lpm_pkg::INT_GLOBAL_BIT]; // Global enable
	wire [lpm_pkg::NUM_SRC-1:0] srcEn = intCtrl_q[lpm_pkg::NUM_SRC-1:0]; // Per source enables
	wire [lpm_pkg::EXT_NUM-1:0] edgeMode = intCtrl_q[lpm_pkg::INT_EDGE_LSB +: lpm_pkg::EXT_NUM];
	wire [lpm_pkg::NUM_SRC-1:0] enabledReq = intReq & srcEn & {lpm_pkg::NUM_SRC{globalEn}};
	wire anyEnabled = |enabledReq; // Idle wake source
	wire [lpm_pkg::EXT_NUM-1:0] extLow; // Level external wake per pin
	// Only enabled level-sensitive pins act in power-down
	assign extLow[0] = !pinLevel[0] && !edgeMode[0] && globalEn && srcEn[lpm_pkg::SRC_EXT0];
	assign extLow[1] = !pinLevel[1] && !edgeMode[1] && globalEn && srcEn[lpm_pkg::SRC_EXT1];
	wire extLowAny = |extLow; // Any wake pin low

	// ------------------------------------------------------------
	// Priority levels and in-service ceiling
	// ------------------------------------------------------------
	logic [lpm_pkg::LVL_W-1:0] srcLvl [lpm_pkg::NUM_SRC]; // Level per source
	logic [lpm_pkg::NUM_SRC-1:0] eligible; // Request above ceiling
	logic servBusy; // Some level in service
	logic [lpm_pkg::LVL_W-1:0] servTop; // Highest level in service

	// Highest in-service level
	always_comb begin
		servBusy = 1'b0;
		servTop = '0;
		for (int l = 0; l < lpm_pkg::NUM_LVL; l++) begin
			if (inServ_q[l]) begin
				servBusy = 1'b1;
				servTop = lpm_pkg::LVL_W'(l);
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < lpm_pkg::NUM_SRC; g++) begin : gSrc
			// High bit is the level's upper bit
			assign srcLvl[g] = {prioHigh_q[g], prioLow_q[g]};
			assign eligible[g] = enabledReq[g] && (!servBusy || (srcLvl[g] > servTop));
		end
	endgenerate

	logic pickValid; // A request wins
	logic [lpm_pkg::SRC_W-1:0] pickSrc; // Winning source
	logic [lpm_pkg::LVL_W-1:0] pickLvl; // Winning level

	// Strictly higher level replaces, so lower index wins ties
	always_comb begin
		pickValid = 1'b0;
		pickSrc = '0;
		pickLvl = '0;
		for (int i = 0; i < lpm_pkg::NUM_SRC; i++) begin
			if (eligible[i] && (!pickValid || (srcLvl[i] > pickLvl))) begin
				pickValid = 1'b1;
				pickSrc = lpm_pkg::SRC_W'(i);
				pickLvl = srcLvl[i];
			end
		end
	end

	// ------------------------------------------------------------
	// Mode state machine
	// ------------------------------------------------------------
	wire holdDone = (wakeCnt_q >= lpm_pkg::WAKE_HOLD_CYCLES); // Held long enough

	always_comb begin
		state_d = state_q;
		wakeCnt_d = wakeCnt_q;
		case (state_q)
			lpm_pkg::ST_RUN: begin
				if (pdownReq) begin
					state_d = lpm_pkg::ST_PDOWN;
				end else if (idleReq) begin
					state_d = lpm_pkg::ST_IDLE;
				end
			end
			lpm_pkg::ST_IDLE: begin
				if (anyEnabled) begin
					state_d = lpm_pkg::ST_RUN;
				end
			end
			lpm_pkg::ST_PDOWN: begin
				if (extLowAny) begin
					state_d = lpm_pkg::ST_WAKE_HOLD;
					wakeCnt_d = lpm_pkg::WAKE_CNT_ONE;
				end
			end
			lpm_pkg::ST_WAKE_HOLD: begin
				if (extLowAny) begin
					// Count saturates once the hold is met
					if (!holdDone) begin
						wakeCnt_d = wakeCnt_q + lpm_pkg::WAKE_CNT_ONE;
					end
				// Service only after the pin is high again
				end else if (holdDone) begin
					state_d = lpm_pkg::ST_RUN;
				// Released too early, back to power-down
				end else begin
					state_d = lpm_pkg::ST_PDOWN;
				end
			end
			default: begin
				state_d = lpm_pkg::ST_RUN;
			end
		endcase
	end

	// Reset restarts everything as from power-on
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= lpm_pkg::ST_RUN;
			wakeCnt_q <= '0;
		end else begin
			state_q <= state_d;
			wakeCnt_q <= wakeCnt_d;
		end
	end

	wire stIdle = (state_q == lpm_pkg::ST_IDLE); // In idle
	wire stPdown = (state_q == lpm_pkg::ST_PDOWN); // Power-down, clock off
	wire stHold = (state_q == lpm_pkg::ST_WAKE_HOLD); // Oscillator restarting

	// Program counter halts in every low power state
	// Core halts after the entering write, so it resumes at the next instruction
	assign cpuHalt = (state_q != lpm_pkg::ST_RUN);
	// Clock gated only in power-down proper
	assign sysClkEnable = !stPdown;

	// ------------------------------------------------------------
	// Power control request bits
	// ------------------------------------------------------------
	always_comb begin
		powerCtrl_d = powerCtrl_q;
		// Start of service clears the request bits
		if (intAck) begin
			powerCtrl_d = '0;
		end
		// A write in the ack cycle wins over the clear
		if (pwrWrite) begin
			powerCtrl_d = hwdata[1:0];
		end
	end

	// ------------------------------------------------------------
	// In-service levels
	// ------------------------------------------------------------
	always_comb begin
		inServ_d = inServ_q;
		// Return drops the top level in service
		if (retiDone && servBusy) begin
			inServ_d[servTop] = 1'b0;
		end
		// Taking an interrupt marks its level, after any return
		if (intAck && intValid_q) begin
			inServ_d[intLevel_q] = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Registers written by software
	// ------------------------------------------------------------
	// No mode touches these; besides bus writes and reset, intAck clears powerCtrl_q and intAck and retiDone change inServ_q
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			powerCtrl_q <= lpm_pkg::PWR_RESET;
			intCtrl_q <= lpm_pkg::INT_CTRL_RESET;
			prioLow_q <= lpm_pkg::PRIO_RESET;
			prioHigh_q <= lpm_pkg::PRIO_RESET;
			inServ_q <= '0;
		end else begin
			powerCtrl_q <= powerCtrl_d;
			inServ_q <= inServ_d;
			if (intCtrlWrite) begin
				intCtrl_q <= hwdata[lpm_pkg::INT_CTRL_W-1:0];
			end
			if (prioLowWrite) begin
				prioLow_q <= hwdata[7:0] & lpm_pkg::PRIO_FIELD_MASK;
			end
			// Same six fields, reserved bits zero
			if (prioHighWrite) begin
				prioHigh_q <= hwdata[7:0] & lpm_pkg::PRIO_FIELD_MASK;
			end
		end
	end

	// ------------------------------------------------------------
	// Bus slave pipeline and read mux
	// ------------------------------------------------------------
	wire [7:0] statusWord = {inServ_q, 1'b0, stHold, stPdown || stHold, stIdle};
	wire [31:0] readMux =
		(busAddr == lpm_pkg::PWR_CTRL_ADDR) ? {30'h0, powerCtrl_q} :
		(busAddr == lpm_pkg::INT_CTRL_ADDR) ? {22'h0, intCtrl_q} :
		(busAddr == lpm_pkg::STATUS_ADDR) ? {24'h0, statusWord} :
		(busAddr == lpm_pkg::PRIO_HIGH_ADDR) ? {24'h0, prioHigh_q} :
		(busAddr == lpm_pkg::PRIO_LOW_ADDR) ? {24'h0, prioLow_q} : 32'h0;

	// Address phase capture and read data
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			wrPend_q <= 1'b0;
			wrAddr_q <= '0;
			hrdata_q <= '0;
		end else begin
			wrPend_q <= writeTake;
			if (writeTake) begin
				wrAddr_q <= busAddr;
			end
			if (readTake) begin
				hrdata_q <= readMux;
			end
		end
	end

	assign hreadyout = !readStall;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;

	// ------------------------------------------------------------
	// Registered outputs to the core
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			intValid_q <= 1'b0;
			intSource_q <= '0;
			intLevel_q <= '0;
			ale_q <= 1'b0;
			pss_q <= 1'b0;
		end else begin
			intValid_q <= pickValid && !cpuHalt;
			intSource_q <= pickSrc;
			intLevel_q <= pickLvl;
			if (stIdle) begin
				ale_q <= 1'b1;
				pss_q <= 1'b1;
			end else if (stPdown || stHold) begin
				ale_q <= 1'b0;
				pss_q <= 1'b0;
			end else begin
				ale_q <= coreAle;
				pss_q <= coreProgramStoreStrobe;
			end
		end
	end

	assign intValid = intValid_q;
	assign intSource = intSource_q;
	assign intLevel = intLevel_q;
	assign addrLatchStrobe = ale_q;
	assign programStoreStrobe = pss_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_idle_entry: assert property (@(posedge ref_clk) disable iff (!rstn)
		(state_q == lpm_pkg::ST_RUN) && idleReq && !pdownReq |=> stIdle)
		else $error("idle request did not enter idle");

	a_idle_clock: assert property (@(posedge ref_clk) disable iff (!rstn)
		stIdle |-> cpuHalt && sysClkEnable)
		else $error("idle must halt core with clock running");

	a_ack_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
		intAck && !pwrWrite |=> (powerCtrl_q == lpm_pkg::PWR_RESET))
		else $error("service start did not clear request bits");

	a_pdown_clock: assert property (@(posedge ref_clk) disable iff (!rstn)
		stPdown |-> !sysClkEnable && cpuHalt)
		else $error("clock not stopped in power-down");

	a_short_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
		stHold && !extLowAny && (wakeCnt_q < lpm_pkg::WAKE_HOLD_CYCLES) |=> stPdown)
		else $error("short pin pulse completed the wake");

	a_halt_pin_low: assert property (@(posedge ref_clk) disable iff (!rstn)
		stHold && extLowAny |=> cpuHalt)
		else $error("core released while wake pin still low");

	a_strobe_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
		stIdle ##1 stIdle |-> addrLatchStrobe && programStoreStrobe)
		else $error("strobes not high in idle");

	a_strobe_pdown: assert property (@(posedge ref_clk) disable iff (!rstn)
		stPdown ##1 stPdown |-> !addrLatchStrobe && !programStoreStrobe)
		else $error("strobes not low in power-down");

	a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
		(prioHigh_q[7:6] == 2'h0) && (prioLow_q[7:6] == 2'h0))
		else $error("reserved priority bits set");

	a_tie_order: assert property (@(posedge ref_clk) disable iff (!rstn)
		pickValid && eligible[0] && (srcLvl[0] == pickLvl) |-> (pickSrc == lpm_pkg::SRC_EXT0))
		else $error("tie not resolved to first polled source");

endmodule // low_power_mode_and_priority

/* File: rtl/pin_sync.sv */
// Three stage synchroniser with agreement filter for the external interrupt pins
`timescale 1ns/1ns
module pin_sync (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Raw pins and filtered levels
	input wire logic [lpm_pkg::EXT_NUM-1:0] pinRaw,
	output logic [lpm_pkg::EXT_NUM-1:0] pinLevel
);

	// ------------------------------------------------------------
	// Stages
	// ------------------------------------------------------------
	logic [lpm_pkg::EXT_NUM-1:0] stage1_q; // Metastable stage, read by stage2 only
	logic [lpm_pkg::EXT_NUM-1:0] stage2_q; // Second stage
	logic [lpm_pkg::EXT_NUM-1:0] stage3_q; // Third stage
	logic [lpm_pkg::EXT_NUM-1:0] level_q; // Accepted level
	logic [lpm_pkg::EXT_NUM-1:0] level_d; // Next accepted level

	// A change counts once stages two and three agree
	genvar g;
	generate
		for (g = 0; g < lpm_pkg::EXT_NUM; g++) begin : gAgree
			assign level_d[g] = (stage2_q[g] == stage3_q[g]) ? stage3_q[g] : level_q[g];
		end
	endgenerate

	// Shift chain, pins rest high
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			stage1_q <= lpm_pkg::PIN_IDLE_LEVEL;
			stage2_q <= lpm_pkg::PIN_IDLE_LEVEL;
			stage3_q <= lpm_pkg::PIN_IDLE_LEVEL;
			level_q <= lpm_pkg::PIN_IDLE_LEVEL;
		end else begin
			stage1_q <= pinRaw;
			stage2_q <= stage1_q;
			stage3_q <= stage2_q;
			level_q <= level_d;
		end
	end

	assign pinLevel = level_q;

endmodule // pin_sync

/* File: sim/cpu_side_model.sv */
// Behavioural CPU core, strobe source and wake pin driver
`timescale 1ns/1ns
module cpu_side_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// Bench commands
	input wire logic ackEn,
	input wire logic pinLow,
	// Interrupt handshake
	input wire logic intValid,
	output logic intAck,
	output logic retiDone,
	// Core strobes and pins
	output logic coreAle,
	output logic coreProgramStoreStrobe,
	output logic [lpm_pkg::EXT_NUM-1:0] extIntPinN
);
	logic [3:0] svcCnt_q; // Cycles left in the service routine

	assign extIntPinN = {1'b1, ~pinLow};

	// Strobes toggle so the block must override them; ack then return
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			intAck <= 1'b0;
			retiDone <= 1'b0;
			svcCnt_q <= 4'h0;
			coreAle <= 1'b0;
			coreProgramStoreStrobe <= 1'b1;
		end else begin
			coreAle <= ~coreAle;
			coreProgramStoreStrobe <= coreAle;
			intAck <= 1'b0;
			retiDone <= 1'b0;
			if (svcCnt_q != 4'h0) begin
				svcCnt_q <= svcCnt_q - 4'h1;
				retiDone <= (svcCnt_q == 4'h1);
			end else if (ackEn && intValid === 1'b1 && !intAck) begin
				intAck <= 1'b1;
				svcCnt_q <= 4'h6;
			end
		end
	end
endmodule // cpu_side_model

/* File: sim/tb_top.sv */
// Self-checking bench for the low power mode and priority block
`timescale 1ns/1ns
module tb_top;
	localparam logic [11:0] PH = lpm_pkg::PRIO_HIGH_ADDR;
	localparam logic [11:0] PL = lpm_pkg::PRIO_LOW_ADDR;
	localparam logic [11:0] PW = lpm_pkg::PWR_CTRL_ADDR;
	logic ref_clk, rstn, hsel, hwrite, hreadyout, hresp, ackEn, pinLow;
	logic intAck, retiDone, intValid, cpuHalt, sysClkEnable, coreAle, corePss, ale, pss;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, intLevel, pinN;
	logic [2:0] hsize, intSource;
	logic [5:0] intReq;
	int nMismatch = 0;
	int samplesChecked = 0;

	low_power_mode_and_priority uut (.ref_clk(ref_clk), .rstn(rstn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.intReq(intReq), .intAck(intAck), .retiDone(retiDone), .intValid(intValid),
		.intSource(intSource), .intLevel(intLevel), .extIntPinN(pinN), .cpuHalt(cpuHalt),
		.sysClkEnable(sysClkEnable), .coreAle(coreAle), .coreProgramStoreStrobe(corePss),
		.addrLatchStrobe(ale), .programStoreStrobe(pss));
	cpu_side_model cpu (.ref_clk(ref_clk), .rstn(rstn), .ackEn(ackEn), .pinLow(pinLow),
		.intValid(intValid), .intAck(intAck), .retiDone(retiDone), .coreAle(coreAle),
		.coreProgramStoreStrobe(corePss), .extIntPinN(pinN));

	// Clock of 8 ns period
	always #4 ref_clk = ~ref_clk;

	// Report and end the run
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samplesChecked, nMismatch);
		if (nMismatch == 0 && samplesChecked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Compare one value
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			nMismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// Bounded wait on cpuHalt (sel 0), intAck (sel 1) or hready (sel 2)
	task automatic wait_sig(input int sel, input logic v);
		int k;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (((sel == 0) ? cpuHalt : (sel == 1) ? intAck : hreadyout) !== v && k < 3000);
		if (k >= 3000) begin
			nMismatch++;
			tally_and_finish();
		end
	endtask

	// One single AHB transfer, held until hready is seen high
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {20'h00000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		wait_sig(2, 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_sig(2, 1'b1);
		q = hrdata;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h00000000, q);
		check(q, exp);
		check(hresp, 1'b0);
	endtask

	// Reset values, reserved bits, unmapped place
	task automatic regs_scn();
		rdchk(PH, 32'h00000000);
		rdchk(PL, 32'h00000000);
		wr(PH, 32'h000000FF);
		wr(PL, 32'h000000C5);
		rdchk(PH, 32'h0000003F);
		rdchk(PL, 32'h00000005);
		wr(12'h100, 32'hFFFFFFFF);
		rdchk(12'h100, 32'h00000000);
	endtask

	// Winner and level for given priority bytes
	task automatic prio_case(input logic [7:0] h, input logic [7:0] l, input logic [5:0] req,
		input logic [2:0] src, input logic [1:0] lvl);
		wr(PH, {24'h000000, h});
		wr(PL, {24'h000000, l});
		intReq <= req;
		cyc(3);
		check(intValid, 1'b1);
		check(intSource, src);
		check(intLevel, lvl);
		intReq <= 6'h00;
		cyc(2);
	endtask

	task automatic prio_scn();
		wr(lpm_pkg::INT_CTRL_ADDR, 32'h000000BF);
		prio_case(8'h20, 8'h01, 6'h3F, 3'h5, 2'h2);
		prio_case(8'h00, 8'h00, 6'h1E, 3'h1, 2'h0);
		prio_case(8'h3F, 8'h3F, 6'h0C, 3'h2, 2'h3);
	endtask

	// Idle entry, strobes, wake by enabled interrupt
	task automatic idle_scn();
		wr(PH, 32'h00000015);
		wr(PW, 32'h00000001);
		cyc(3);
		check(cpuHalt, 1'b1);
		check(sysClkEnable, 1'b1);
		check({ale, pss}, 2'h3);
		cyc(1);
		check({ale, pss}, 2'h3);
		ackEn <= 1'b1;
		intReq <= 6'h02;
		wait_sig(0, 1'b0);
		wait_sig(1, 1'b1);
		intReq <= 6'h00;
		rdchk(PW, 32'h00000000);
		rdchk(PH, 32'h00000015);
	endtask

	// Power-down, short pulse refused, long hold wakes
	task automatic pd_scn();
		wr(PW, 32'h00000002);
		cyc(3);
		check(sysClkEnable, 1'b0);
		check({ale, pss}, 2'h0);
		intReq <= 6'h02;
		pinLow <= 1'b1;
		cyc(100);
		pinLow <= 1'b0;
		cyc(20);
		check(cpuHalt, 1'b1);
		check(sysClkEnable, 1'b0);
		intReq <= 6'h01;
		pinLow <= 1'b1;
		cyc(1050);
		check(cpuHalt, 1'b1);
		check(intValid, 1'b0);
		pinLow <= 1'b0;
		wait_sig(0, 1'b0);
		wait_sig(1, 1'b1);
		intReq <= 6'h00;
		rdchk(PW, 32'h00000000);
		rdchk(PH, 32'h00000015);
	endtask

	// Reset in idle restarts like power-on
	task automatic rst_scn();
		wr(PW, 32'h00000001);
		cyc(2);
		rstn <= 1'b0;
		cyc(2);
		check(cpuHalt, 1'b0);
		rstn <= 1'b1;
		cyc(1);
		rdchk(PH, 32'h00000000);
		rdchk(PW, 32'h00000000);
	endtask

	// Main sequence
	initial begin
		ref_clk = 1'b0;
		rstn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		intReq = 6'h00;
		ackEn = 1'b0;
		pinLow = 1'b0;
		cyc(3);
		rstn <= 1'b1;
		cyc(1);
		regs_scn();
		prio_scn();
		idle_scn();
		pd_scn();
		rst_scn();
		tally_and_finish();
	end
endmodule // tb_top
